// [oss_sync_status.sv]
// Purpose: completion sync for *OPC/*OPC?/*WAI and status byte / SRQ / IST summary
// Assumes: command parser, overlap engine and status sources on sys_clk
// Notes: apb zero-wait slave; level irq
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module oss_sync_status #(
    parameter int PEND_W = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    output logic cmdReady,
    input wire logic opDone,
    input wire logic [7:1] esrEvt,
    input wire logic operSum,
    input wire logic quesSum,
    input wire logic errQueueNotEmpty,
    input wire logic extMsgAvail,
    output logic respValid,
    output logic [7:0] respData,
    input wire logic respReady,
    output logic srq,
    output logic istFlag,
    output logic irq
);
    logic rstMeta_reg, rstn;
    logic [7:0] ese_reg, sre_reg, ppe_reg;
    logic [PEND_W-1:0] pending_reg;
    logic opcArmed_reg;
    oss_pkg::oss_state_t state_reg;
    logic respValid_reg;
    logic [7:0] respData_reg;
    logic rqs_reg;
    logic [7:0] stbMaskedPrev_reg;
    logic [oss_pkg::IRQ_W-1:0] irqStat_reg, irqEn_reg;
    logic [31:0] prdata_reg;
    logic cmdTake, cmdOvl, cmdOpc, cmdOpcQ, cmdWai, cmdCls;
    logic noPending, opcFire, qRespond, waiRelease;
    logic apbWr, apbRd, apbSetup, mapped;
    logic esrRdClr, spollRd;
    logic [7:0] esrSet, esrEvent, stb, stbMasked;
    logic esb, mav, srqRise;
    logic [7:0] esrLate_reg;
    logic [oss_pkg::IRQ_W-1:0] irqHit;

    // reset released through two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstn <= rstMeta_reg;
        end
    end

    // command acceptance
    assign cmdReady = (state_reg == oss_pkg::ST_IDLE) && !respValid_reg;
    assign cmdTake = cmdValid && cmdReady && clkEn;
    assign cmdOvl = cmdTake && (cmdCode == oss_pkg::CMD_OVERLAP);
    assign cmdOpc = cmdTake && (cmdCode == oss_pkg::CMD_OPC);
    assign cmdOpcQ = cmdTake && (cmdCode == oss_pkg::CMD_OPC_QUERY);
    assign cmdWai = cmdTake && (cmdCode == oss_pkg::CMD_WAI);
    assign cmdCls = cmdTake && (cmdCode == oss_pkg::CMD_CLS);

    // outstanding overlapped operations; a done pulse with none pending is ignored
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pending_reg <= '0;
        end else if (clkEn) begin
            if (cmdOvl && !(opDone && pending_reg != '0)) begin
                pending_reg <= pending_reg + PEND_W'(1);
            end else if (!cmdOvl && opDone && pending_reg != '0) begin
                pending_reg <= pending_reg - PEND_W'(1);
            end
        end
    end
    assign noPending = (pending_reg == '0);

    // armed completion request; clear-status drops it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            opcArmed_reg <= 1'b0;
        end else if (clkEn) begin
            if (cmdCls || opcFire) begin
                opcArmed_reg <= 1'b0;
            end else if (cmdOpc) begin
                opcArmed_reg <= 1'b1;
            end
        end
    end
    // only fires once every earlier command has finished
    assign opcFire = opcArmed_reg && noPending;

    assign qRespond = (state_reg == oss_pkg::ST_WAIT_OPCQ) && noPending && clkEn;
    assign waiRelease = (state_reg == oss_pkg::ST_WAIT_WAI) && noPending && clkEn;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= oss_pkg::ST_IDLE;
        end else if (clkEn) begin
            case (state_reg)
                oss_pkg::ST_IDLE: begin
                    if (cmdWai) begin
                        state_reg <= oss_pkg::ST_WAIT_WAI;
                    end else if (cmdOpcQ) begin
                        state_reg <= oss_pkg::ST_WAIT_OPCQ;
                    end
                end
                oss_pkg::ST_WAIT_WAI: begin
                    if (noPending) begin
                        state_reg <= oss_pkg::ST_IDLE;
                    end
                end
                oss_pkg::ST_WAIT_OPCQ: begin
                    if (noPending) begin
                        state_reg <= oss_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= oss_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // one-entry output buffer for the query answer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            respValid_reg <= 1'b0;
            respData_reg <= 8'h00;
        end else if (clkEn) begin
            if (qRespond) begin
                respValid_reg <= 1'b1;
                respData_reg <= oss_pkg::OPC_ANSWER;
            end else if (respReady) begin
                respValid_reg <= 1'b0;
            end
        end
    end
    assign respValid = respValid_reg;
    assign respData = respData_reg;

    // event status register; query completion also sets the completion bit
    always_comb begin
        esrSet = {esrEvt, 1'b0};
        esrSet[oss_pkg::ESR_OPC] = opcFire || qRespond;
    end

    // a hit in the setup cycle misses the captured read data, so it must survive the clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            esrLate_reg <= 8'h00;
        end else if (clkEn) begin
            esrLate_reg <= (apbSetup && paddr == oss_pkg::ADDR_ESR) ? esrSet : 8'h00;
        end
    end

    oss_status_reg #(
        .WIDTH(8)
    ) u_esr (
        .sysClk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .cond(8'h00),
        .setEvt(esrSet | esrLate_reg),
        .ptr(8'h00),
        .ntr(8'h00),
        .enable(ese_reg),
        .rdClr(esrRdClr),
        .clrAll(cmdCls),
        .event_reg(esrEvent),
        .sum(esb)
    );

    assign mav = respValid_reg || extMsgAvail;

    // status byte: top of the hierarchy
    always_comb begin
        stb = 8'h00;
        stb[oss_pkg::STB_ERRQ] = errQueueNotEmpty;
        stb[oss_pkg::STB_QUES] = quesSum;
        stb[oss_pkg::STB_MAV] = mav;
        stb[oss_pkg::STB_ESB] = esb;
        stb[oss_pkg::STB_OPER] = operSum;
        stb[oss_pkg::STB_RQS] = rqs_reg;
    end

    // position 6 is the summary itself, so its enable is dropped
    assign stbMasked = stb & sre_reg & 8'hBF;
    assign srqRise = |(stbMasked & ~stbMaskedPrev_reg);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stbMaskedPrev_reg <= 8'h00;
        end else if (clkEn) begin
            stbMaskedPrev_reg <= stbMasked;
        end
    end

    // request latch cleared by serial poll read; a new rise wins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rqs_reg <= 1'b0;
        end else if (clkEn) begin
            if (srqRise) begin
                rqs_reg <= 1'b1;
            end else if (spollRd || cmdCls) begin
                rqs_reg <= 1'b0;
            end
        end
    end
    assign srq = rqs_reg;
    assign istFlag = |(stb & ppe_reg);

    // apb: zero wait state, read data captured in setup
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pwrite && clkEn;
    assign apbRd = psel && penable && !pwrite && clkEn;
    assign pready = 1'b1;
    always_comb begin
        case (paddr)
            oss_pkg::ADDR_ESE, oss_pkg::ADDR_SRE, oss_pkg::ADDR_PPE, oss_pkg::ADDR_ESR,
            oss_pkg::ADDR_STB, oss_pkg::ADDR_SPOLL, oss_pkg::ADDR_STATE,
            oss_pkg::ADDR_IRQ_STAT, oss_pkg::ADDR_IRQ_EN, oss_pkg::ADDR_IRQ_CLR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;
    assign esrRdClr = apbRd && (paddr == oss_pkg::ADDR_ESR);
    assign spollRd = apbRd && (paddr == oss_pkg::ADDR_SPOLL);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ese_reg <= oss_pkg::ESE_RST;
            sre_reg <= oss_pkg::SRE_RST;
            ppe_reg <= oss_pkg::PPE_RST;
            irqEn_reg <= '0;
        end else if (apbWr) begin
            case (paddr)
                oss_pkg::ADDR_ESE: ese_reg <= pwdata[7:0];
                oss_pkg::ADDR_SRE: sre_reg <= pwdata[7:0];
                oss_pkg::ADDR_PPE: ppe_reg <= pwdata[7:0];
                oss_pkg::ADDR_IRQ_EN: irqEn_reg <= pwdata[oss_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (clkEn && apbSetup) begin
            case (paddr)
                oss_pkg::ADDR_ESE: prdata_reg <= {24'h00_0000, ese_reg};
                oss_pkg::ADDR_SRE: prdata_reg <= {24'h00_0000, sre_reg & 8'hBF};
                oss_pkg::ADDR_PPE: prdata_reg <= {24'h00_0000, ppe_reg};
                oss_pkg::ADDR_ESR: prdata_reg <= {24'h00_0000, esrEvent};
                oss_pkg::ADDR_STB, oss_pkg::ADDR_SPOLL: prdata_reg <= {24'h00_0000, stb};
                oss_pkg::ADDR_STATE: prdata_reg <= {21'h00_0000, state_reg, opcArmed_reg,
                                                    {(8 - PEND_W){1'b0}}, pending_reg};
                oss_pkg::ADDR_IRQ_STAT: prdata_reg <= {28'h000_0000, irqStat_reg};
                oss_pkg::ADDR_IRQ_EN: prdata_reg <= {28'h000_0000, irqEn_reg};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_reg;

    // interrupt: sticky status, set wins over write-one-to-clear
    always_comb begin
        irqHit = '0;
        irqHit[oss_pkg::IRQ_OPC] = opcFire || qRespond;
        irqHit[oss_pkg::IRQ_SRQ] = srqRise;
        irqHit[oss_pkg::IRQ_QRESP] = qRespond;
        irqHit[oss_pkg::IRQ_RELEASE] = waiRelease;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqStat_reg <= '0;
        end else if (clkEn) begin
            if (apbWr && paddr == oss_pkg::ADDR_IRQ_CLR) begin
                irqStat_reg <= (irqStat_reg & ~pwdata[oss_pkg::IRQ_W-1:0]) | irqHit;
            end else begin
                irqStat_reg <= irqStat_reg | irqHit;
            end
        end
    end
    assign irq = |(irqStat_reg & irqEn_reg);
endmodule // oss_sync_status
`default_nettype wire

// [oss_pkg.sv]
// Purpose: shared constants for the completion-sync and status-summary block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
package oss_pkg;
    localparam logic [7:0] ADDR_ESE = 8'h00;
    localparam logic [7:0] ADDR_SRE = 8'h04;
    localparam logic [7:0] ADDR_PPE = 8'h08;
    localparam logic [7:0] ADDR_ESR = 8'h0C;
    localparam logic [7:0] ADDR_STB = 8'h10;
    localparam logic [7:0] ADDR_SPOLL = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h24;
    // event status bit positions
    localparam int ESR_OPC = 0;
    // status byte bit positions
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OPER = 7;
    // interrupt status bit positions
    localparam int IRQ_OPC = 0;
    localparam int IRQ_SRQ = 1;
    localparam int IRQ_QRESP = 2;
    localparam int IRQ_RELEASE = 3;
    localparam int IRQ_W = 4;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] PPE_RST = 8'h00;
    localparam logic [7:0] OPC_ANSWER = 8'h01;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [2:0] {
        CMD_OTHER = 3'b000,
        CMD_OVERLAP = 3'b001,
        CMD_OPC = 3'b010,
        CMD_OPC_QUERY = 3'b011,
        CMD_WAI = 3'b100,
        CMD_CLS = 3'b101
    } oss_cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_WAI = 2'b01,
        ST_WAIT_OPCQ = 2'b10
    } oss_state_t;
endpackage

// [oss_status_reg.sv]
// Purpose: one status register level: condition, transition filters, event, enable, sum
// Assumes: all inputs on sys_clk
// Notes: set wins over read-clear
`timescale 1ns/1ps
`default_nettype none
module oss_status_reg #(
    parameter int WIDTH = 8
) (
    input wire logic sysClk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] cond,
    input wire logic [WIDTH-1:0] setEvt,
    input wire logic [WIDTH-1:0] ptr,
    input wire logic [WIDTH-1:0] ntr,
    input wire logic [WIDTH-1:0] enable,
    input wire logic rdClr,
    input wire logic clrAll,
    output logic [WIDTH-1:0] event_reg,
    output logic sum
);
    logic [WIDTH-1:0] condPrev_reg;
    logic [WIDTH-1:0] hit;

    assign hit = setEvt | (cond & ~condPrev_reg & ptr) | (~cond & condPrev_reg & ntr);

    always_ff @(posedge sysClk or negedge rstn) begin
        if (!rstn) begin
            condPrev_reg <= '0;
        end else if (clkEn) begin
            condPrev_reg <= cond;
        end
    end

    always_ff @(posedge sysClk or negedge rstn) begin
        if (!rstn) begin
            event_reg <= '0;
        end else if (clkEn) begin
            if (rdClr || clrAll) begin
                event_reg <= hit;
            end else begin
                event_reg <= event_reg | hit;
            end
        end
    end

    assign sum = |(event_reg & enable);
endmodule // oss_status_reg
`default_nettype wire

// [oss_sync_status_checker.sv]
// Purpose: port-level assertions for the completion-sync block
// Assumes: one clock domain, clkEn held high by the bench except for one frozen write
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module oss_sync_status_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic cmdReady,
    input wire logic respValid,
    input wire logic [7:0] respData,
    input wire logic respReady
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("apb access not answered at once");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access without slave error");
    a_unmapped_rd: assert property (psel && penable && !pwrite && paddr > 8'h24 |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_sre_bit6: assert property (psel && penable && !pwrite && paddr == oss_pkg::ADDR_SRE |-> !prdata[6])
        else $error("request enable bit 6 reads set");
    a_wait_blocks: assert property (clkEn && cmdValid && cmdReady && cmdCode == 3'h4 |=> !cmdReady)
        else $error("wait command did not hold off commands");
    a_query_blocks: assert property (clkEn && cmdValid && cmdReady && cmdCode == 3'h3 |=> !cmdReady)
        else $error("completion query did not hold off commands");
    a_query_answer: assert property ($rose(respValid) |-> respData == oss_pkg::OPC_ANSWER && !$past(cmdReady))
        else $error("completion answer wrong or unblocked");
    a_resp_holds: assert property (clkEn && respValid && !respReady |=> respValid)
        else $error("answer dropped before it was taken");
    a_resp_stalls: assert property (respValid |-> !cmdReady)
        else $error("commands accepted with answer unread");
endmodule // oss_sync_status_checker
bind oss_sync_status oss_sync_status_checker i_oss_sync_status_checker (.sys_clk(sys_clk), .resetn(resetn),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReady(cmdReady),
    .respValid(respValid), .respData(respData), .respReady(respReady));
`default_nettype wire

// [oss_ctrl_model.sv]
// Purpose: remote controller issuing commands and reading answers
// Assumes: driven from the bench through send and hold
// Notes: idle command code is the inverse of the last one
`timescale 1ns/1ps
`default_nettype none
module oss_ctrl_model (
    input wire logic sys_clk,
    input wire logic cmdReady,
    input wire logic respValid,
    output var logic cmdValid,
    output var logic [2:0] cmdCode,
    output var logic respReady
);
    logic hold = 1'h0;
    initial begin
        cmdValid = 1'h0;
        cmdCode = 3'h0;
        respReady = 1'h0;
    end
    task automatic send(input logic [2:0] c);
        cmdValid <= 1'h1;
        cmdCode <= c;
        do @(posedge sys_clk); while (cmdReady !== 1'h1);
        cmdValid <= 1'h0;
        cmdCode <= ~c;
        // one idle edge so a following send never re-raises valid in the same step
        @(posedge sys_clk);
    endtask
    // slow reader: hold keeps the answer waiting
    always @(posedge sys_clk) begin
        respReady <= (respValid === 1'h1) && !hold && !respReady;
    end
endmodule // oss_ctrl_model
`default_nettype wire

// [oss_sync_status_bench.sv]
// Purpose: self-checking bench for the completion-sync block
// Assumes: 25 MHz clock, zero-wait apb
// Notes: overlapped work is finished by pulsing opDone
`timescale 1ns/1ps
`default_nettype none
module oss_sync_status_bench;
    logic sys_clk, resetn, clkEn, psel, penable, pwrite, pready, pslverr, cmdValid, cmdReady, opDone;
    logic operSum, quesSum, errQ, extMsgAvail, respValid, respReady, srq, istFlag, irq, rerr;
    logic [7:0] paddr, respData;
    logic [7:1] esrEvt;
    logic [2:0] cmdCode;
    logic [31:0] pwdata, prdata, rdata;
    int n_mismatch = 0;
    int n_tests = 0;
    oss_sync_status i_oss_sync_status (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReady(cmdReady), .opDone(opDone),
        .esrEvt(esrEvt), .operSum(operSum), .quesSum(quesSum), .errQueueNotEmpty(errQ),
        .extMsgAvail(extMsgAvail), .respValid(respValid), .respData(respData), .respReady(respReady),
        .srq(srq), .istFlag(istFlag), .irq(irq));
    oss_ctrl_model i_oss_ctrl_model (.sys_clk(sys_clk), .cmdReady(cmdReady), .respValid(respValid),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .respReady(respReady));
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk(n, e, rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic finish_op;
        opDone <= 1'h1;
        tick(1);
        opDone <= 1'h0;
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        resetn = 1'h0;
        clkEn = 1'h1;
        {psel, penable, pwrite, opDone, operSum, quesSum, errQ, extMsgAvail} = 8'h00;
        {paddr, pwdata, esrEvt} = 47'h0000_0000_0000;
        tick(6);
        resetn <= 1'h1;
        tick(3);
        rd("ese", oss_pkg::ADDR_ESE, 32'h0000_0000);
        rd("ppe", oss_pkg::ADDR_PPE, 32'h0000_0000);
        apb(1'h1, oss_pkg::ADDR_SRE, 32'h0000_00FF);
        rd("sre", oss_pkg::ADDR_SRE, 32'h0000_00BF);
        rd("unmapped", 8'h28, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0000_0000, rerr});
        apb(1'h1, oss_pkg::ADDR_ESE, 32'h0000_0001);
        i_oss_ctrl_model.send(oss_pkg::CMD_OVERLAP);
        i_oss_ctrl_model.send(oss_pkg::CMD_OPC);
        tick(2);
        rd("esr early", oss_pkg::ADDR_ESR, 32'h0000_0000);
        rd("state", oss_pkg::ADDR_STATE, 32'h0000_0101);
        finish_op();
        tick(3);
        chk("srq", 32'h0000_0001, {31'h0000_0000, srq});
        chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
        rd("stb esb", oss_pkg::ADDR_STB, 32'h0000_0060);
        rd("poll", oss_pkg::ADDR_SPOLL, 32'h0000_0060);
        rd("stb polled", oss_pkg::ADDR_STB, 32'h0000_0020);
        rd("irq stat", oss_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
        apb(1'h1, oss_pkg::ADDR_IRQ_EN, 32'h0000_000F);
        chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
        apb(1'h1, oss_pkg::ADDR_IRQ_CLR, 32'h0000_0003);
        chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
        rd("esr done", oss_pkg::ADDR_ESR, 32'h0000_0001);
        rd("esr cleared", oss_pkg::ADDR_ESR, 32'h0000_0000);
        // answer held unread to see the message-available bit
        apb(1'h1, oss_pkg::ADDR_SRE, 32'h0000_0010);
        i_oss_ctrl_model.hold <= 1'h1;
        i_oss_ctrl_model.send(oss_pkg::CMD_OVERLAP);
        i_oss_ctrl_model.send(oss_pkg::CMD_OPC_QUERY);
        tick(4);
        chk("query early", 32'h0000_0000, {31'h0000_0000, respValid});
        finish_op();
        tick(3);
        chk("answer", 32'h0000_0001, {24'h00_0000, respData});
        rd("stb mav", oss_pkg::ADDR_STB, 32'h0000_0070);
        i_oss_ctrl_model.hold <= 1'h0;
        tick(4);
        rd("stb read out", oss_pkg::ADDR_STB, 32'h0000_0060);
        rd("poll2", oss_pkg::ADDR_SPOLL, 32'h0000_0060);
        rd("esr query", oss_pkg::ADDR_ESR, 32'h0000_0001);
        i_oss_ctrl_model.send(oss_pkg::CMD_OVERLAP);
        i_oss_ctrl_model.send(oss_pkg::CMD_WAI);
        tick(3);
        chk("wai block", 32'h0000_0000, {31'h0000_0000, cmdReady});
        finish_op();
        tick(2);
        chk("wai free", 32'h0000_0001, {31'h0000_0000, cmdReady});
        {operSum, quesSum, errQ} <= 3'h7;
        tick(2);
        rd("stb sums", oss_pkg::ADDR_STB, 32'h0000_008C);
        errQ <= 1'h0;
        tick(2);
        rd("stb drained", oss_pkg::ADDR_STB, 32'h0000_0088);
        apb(1'h1, oss_pkg::ADDR_PPE, 32'h0000_0080);
        chk("ist on", 32'h0000_0001, {31'h0000_0000, istFlag});
        apb(1'h1, oss_pkg::ADDR_PPE, 32'h0000_0000);
        chk("ist off", 32'h0000_0000, {31'h0000_0000, istFlag});
        // frozen clock enable: the write must not land
        clkEn <= 1'h0;
        apb(1'h1, oss_pkg::ADDR_ESE, 32'h0000_0000);
        clkEn <= 1'h1;
        rd("ese frozen", oss_pkg::ADDR_ESE, 32'h0000_0001);
        summarize();
    end
endmodule // oss_sync_status_bench
`default_nettype wire
